/* pio_pkg.sv */
/*
 Constants, types and decoding shared by the parallel I/O port block.
 Assumes a byte-wide register port with a 4-bit address and one system clock.
*/

package pio_pkg;

	localparam int PIO_PORTS = 8;
	localparam int PIO_WIDTH = 8;

	localparam logic [7:0][3:0] PIO_DATA_OFF = {4'hb, 4'ha, 4'h9, 4'h8, 4'h3, 4'h2, 4'h1, 4'h0};
	localparam logic [7:0][3:0] PIO_DIR_OFF = {4'hf, 4'he, 4'hd, 4'hc, 4'h7, 4'h6, 4'h5, 4'h4};

	// Implemented bits per port, H down to A
	localparam logic [7:0][7:0] PIO_DATA_MASK = {8'h03, 8'h07, 8'h7f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
	localparam logic [7:0][7:0] PIO_DIR_MASK = {8'h03, 8'h07, 8'h7f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
	localparam logic [7:0] PIO_DIR_RESET = 8'h00;
	localparam logic [7:0] PIO_RDATA_IDLE = 8'h00;

	localparam logic [2:0] PIO_PORT_A = 3'h0;
	localparam logic [2:0] PIO_PORT_B = 3'h1;
	localparam logic [2:0] PIO_PORT_C = 3'h2;
	localparam logic [2:0] PIO_PORT_D = 3'h3;
	localparam logic [2:0] PIO_PORT_E = 3'h4;
	localparam logic [2:0] PIO_PORT_H = 3'h7;

	localparam int PIO_CLKOUT_BIT = 7;
	localparam int PIO_CLKOUT_PIN = 2;

	localparam logic [4:0] PIO_ANALOG_D_BASE = 5'h08;
	localparam logic [4:0] PIO_ANALOG_D_END = 5'h0f;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pio_bus_req_type;

	typedef struct packed {
		logic is_data;
		logic is_dir;
		logic [2:0] port;
	} pio_decode_type;

	typedef logic [7:0][7:0] pio_port_array_type;

	// Register address to port and register kind
	function automatic pio_decode_type pio_decode(input logic [3:0] addr);
		pio_decode_type d;
		d = '0;
		for (int i = 0; i < PIO_PORTS; i++) begin
			if (addr == PIO_DATA_OFF[i]) begin
				d.is_data = 1'b1;
				d.port = 3'(i);
			end
			if (addr == PIO_DIR_OFF[i]) begin
				d.is_dir = 1'b1;
				d.port = 3'(i);
			end
		end
		return d;
	endfunction

endpackage

/* pio_sync.sv */
/*
 Two-stage synchroniser for the port pin levels.
 Assumes the inputs are asynchronous to sys_clk; only the second stage is read.
*/
`timescale 1ns/1ps
`default_nettype none

module pio_sync import pio_pkg::*; #(
	parameter int WIDTH = PIO_PORTS * PIO_WIDTH
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage1_next;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage2_next;

	always_comb begin
		stage1_next = async_in;
		stage2_next = stage1_reg;
		if (srst) begin
			stage1_next = '0;
			stage2_next = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
		end
	end

	assign sync_out = stage2_reg;

endmodule

`default_nettype wire

/* pio_ports.sv */
/*
 Eight parallel I/O ports with data latches, direction registers,
 converter pin sharing on ports B and D and a clock output on port C.
 Assumes a byte register port on sys_clk; pins arrive asynchronously and
 the pad logic resolves pin_out and pin_oe onto the wire.
*/
`timescale 1ns/1ps
`default_nettype none

module pio_ports import pio_pkg::*; (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire pio_bus_req_type bus_req,
	output logic [7:0] bus_rdata,
	input wire logic [4:0] analog_channel,
	input wire pio_port_array_type pin_in,
	output pio_port_array_type pin_out,
	output pio_port_array_type pin_oe
);

	pio_port_array_type latch_reg;
	pio_port_array_type latch_next;
	pio_port_array_type dir_reg;
	pio_port_array_type dir_next;
	logic clk_out_en_reg;
	logic clk_out_en_next;
	logic clk_div_reg;
	logic clk_div_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	pio_port_array_type pin_out_reg;
	pio_port_array_type pin_out_next;
	pio_port_array_type pin_oe_reg;
	pio_port_array_type pin_oe_next;

	pio_port_array_type pin_sync;
	pio_port_array_type claim;
	pio_port_array_type read_val;
	pio_decode_type dec;

	// Pin levels pass two flops before any logic looks at them
	pio_sync #(
		.WIDTH(PIO_PORTS * PIO_WIDTH)
	) u_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.clk_en(clk_en),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// Pins taken by the converter's channel select
	function automatic logic [7:0] analog_claim(input logic [4:0] ch, input logic [2:0] port);
		logic [7:0] m;
		m = 8'h00;
		if (port == PIO_PORT_B && ch < PIO_ANALOG_D_BASE) begin
			m[ch[2:0]] = 1'b1;
		end else if (port == PIO_PORT_D && ch >= PIO_ANALOG_D_BASE && ch < PIO_ANALOG_D_END) begin
			m[3'(ch - PIO_ANALOG_D_BASE)] = 1'b1;
		end
		return m;
	endfunction

	assign dec = pio_decode(bus_req.addr);

	genvar g;
	generate
		for (g = 0; g < PIO_PORTS; g++) begin : g_port
			assign claim[g] = analog_claim(analog_channel, 3'(g));
			// Claimed input bits read 0; driven bits read the latch
			assign read_val[g] = ((latch_reg[g] & dir_reg[g])
				| (pin_sync[g] & ~dir_reg[g] & ~claim[g]))
				& PIO_DATA_MASK[g];
		end
	endgenerate

	// Register writes, reset and clock divider
	always_comb begin
		latch_next = latch_reg;
		dir_next = dir_reg;
		clk_out_en_next = clk_out_en_reg;
		clk_div_next = clk_out_en_reg ? ~clk_div_reg : 1'b0;
		if (bus_req.wr) begin
			if (dec.is_data) begin
				latch_next[dec.port] = bus_req.wdata & PIO_DATA_MASK[dec.port];
			end else if (dec.is_dir) begin
				dir_next[dec.port] = bus_req.wdata & PIO_DIR_MASK[dec.port];
				if (dec.port == PIO_PORT_C) begin
					clk_out_en_next = bus_req.wdata[PIO_CLKOUT_BIT];
				end
			end
		end
		if (srst) begin
			// Latches keep their contents across reset
			for (int i = 0; i < PIO_PORTS; i++) begin
				dir_next[i] = PIO_DIR_RESET;
			end
			latch_next = latch_reg;
			clk_out_en_next = 1'b0;
			clk_div_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			latch_reg <= latch_next;
			dir_reg <= dir_next;
			clk_out_en_reg <= clk_out_en_next;
			clk_div_reg <= clk_div_next;
		end
	end

	// Read data stands for one cycle only
	always_comb begin
		rdata_next = PIO_RDATA_IDLE;
		if (bus_req.rd && !srst) begin
			if (dec.is_data) begin
				rdata_next = read_val[dec.port];
				if (dec.port == PIO_PORT_C && clk_out_en_reg) begin
					rdata_next[PIO_CLKOUT_PIN] = 1'b0;
				end
			end else if (dec.is_dir) begin
				rdata_next = dir_reg[dec.port];
				if (dec.port == PIO_PORT_C) begin
					rdata_next[PIO_CLKOUT_BIT] = clk_out_en_reg;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			rdata_reg <= rdata_next;
		end
	end

	// Pad drive; the clock output shows sys_clk/2 since pads come from flops
	always_comb begin
		for (int i = 0; i < PIO_PORTS; i++) begin
			pin_oe_next[i] = dir_reg[i] & ~claim[i];
			pin_out_next[i] = latch_reg[i] & PIO_DATA_MASK[i];
		end
		if (clk_out_en_reg) begin
			pin_oe_next[PIO_PORT_C][PIO_CLKOUT_PIN] = 1'b1;
			pin_out_next[PIO_PORT_C][PIO_CLKOUT_PIN] = clk_div_reg;
		end
		if (srst) begin
			pin_oe_next = '0;
			pin_out_next = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			pin_out_reg <= pin_out_next;
			pin_oe_reg <= pin_oe_next;
		end
	end

	assign bus_rdata = rdata_reg;
	assign pin_out = pin_out_reg;
	assign pin_oe = pin_oe_reg;

	// Checks

	logic [7:0] a_expect;
	assign a_expect = (latch_reg[PIO_PORT_A] & dir_reg[PIO_PORT_A])
		| (pin_sync[PIO_PORT_A] & ~dir_reg[PIO_PORT_A]);

	default clocking cb @(posedge sys_clk);
	endclocking

	default disable iff (srst || !clk_en);

	sequence data_read_s(logic [3:0] a);
		bus_req.rd && bus_req.addr == a;
	endsequence

	sequence data_write_s(logic [3:0] a);
		bus_req.wr && bus_req.addr == a;
	endsequence

	sequence reset_after_write_s;
		data_write_s(PIO_DATA_OFF[0]) ##1 srst;
	endsequence

	read_mux_a: assert property (
		data_read_s(PIO_DATA_OFF[0]) |=> bus_rdata == $past(a_expect)
	) else $error("port A read does not follow per-bit direction");

	rdata_idle_a: assert property (
		!bus_req.rd |=> bus_rdata == PIO_RDATA_IDLE
	) else $error("read data present without a read");

	write_latch_a: assert property (
		data_write_s(PIO_DATA_OFF[4]) |=> latch_reg[PIO_PORT_E] == $past(bus_req.wdata)
	) else $error("port E latch not loaded by write");

	dir_reset_a: assert property (@(posedge sys_clk) disable iff (!clk_en)
		srst |=> dir_reg == '0 && !clk_out_en_reg ##1 pin_oe == '0
	) else $error("reset left a direction bit or drive set");

	latch_keep_a: assert property (@(posedge sys_clk) disable iff (!clk_en)
		reset_after_write_s |=> latch_reg[PIO_PORT_A] == $past(bus_req.wdata, 2)
	) else $error("reset changed port A latch");

	drive_follow_a: assert property (
		data_write_s(PIO_DIR_OFF[0]) ##1 !bus_req.wr [*2]
			|-> pin_oe[PIO_PORT_A] == $past(bus_req.wdata, 2)
	) else $error("port A drive does not follow direction");

	narrow_zero_a: assert property (
		data_read_s(PIO_DATA_OFF[7]) or data_read_s(PIO_DIR_OFF[5])
			|=> bus_rdata[7] == 1'b0 && (!$past(bus_req.addr == PIO_DATA_OFF[7]) || bus_rdata[7:2] == '0)
	) else $error("unimplemented bits read as one");

	dirc_bit6_a: assert property (
		data_read_s(PIO_DIR_OFF[2]) |=> bus_rdata[6] == 1'b0
	) else $error("port C direction bit 6 read as one");

	analog_release_a: assert property (
		analog_channel == 5'h03 |=> !pin_oe[PIO_PORT_B][3]
	) else $error("converter pin still driven");

	clk_out_a: assert property (
		clk_out_en_reg && !bus_req.wr |=> pin_oe[PIO_PORT_C][PIO_CLKOUT_PIN]
			##1 pin_out[PIO_PORT_C][PIO_CLKOUT_PIN] != $past(pin_out[PIO_PORT_C][PIO_CLKOUT_PIN])
	) else $error("clock output not toggling on port C pin 2");

endmodule

`default_nettype wire

/* pio_board.sv */
/*
 Board model for the port pins: each pin the port releases shows a board level.
 Assumes pin_out and pin_oe come straight from the port block.
*/
`timescale 1ns/1ps
`default_nettype none

module pio_board import pio_pkg::*; (
	input wire pio_port_array_type pin_out,
	input wire pio_port_array_type pin_oe,
	input wire pio_port_array_type board_level,
	output pio_port_array_type pin_in
);
	// Driven pins carry the pad value, released ones the board level
	assign pin_in = (pin_out & pin_oe) | (board_level & ~pin_oe);
endmodule

`default_nettype wire

/* parallel_io_ports_bench.sv */
/*
 Self-checking bench for the parallel I/O ports: register map, direction,
 pin readback, converter sharing and reset. Assumes the pio_board pin model.
*/
`timescale 1ns/1ps
`default_nettype none

module parallel_io_ports_bench import pio_pkg::*;;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	pio_bus_req_type bus_req = '0;
	logic [7:0] bus_rdata;
	logic [4:0] analog_channel = 5'h1f;
	pio_port_array_type pin_in, pin_out, pin_oe;
	pio_port_array_type board_level = '0;
	logic [7:0] expq[$];
	logic [7:0] lat [8];
	logic pend = 1'b0;
	logic [7:0] d, e;
	int n_errors = 0;
	int compares = 0;
	int seed = 75;

	initial forever #12.5 sys_clk = ~sys_clk;

	pio_ports dut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .analog_channel(analog_channel), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe));
	pio_board board (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board_level),
		.pin_in(pin_in));

	task check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task close_out;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		expq.push_back(exp);
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
	endtask

	function automatic logic [3:0] data_at(input int p);
		return 4'(p < 4 ? p : p + 4);
	endfunction

	function automatic logic [3:0] dir_at(input int p);
		return 4'(p < 4 ? p + 4 : p + 8);
	endfunction

	// Read data stand in the cycle after the strobe
	always @(posedge sys_clk) pend <= bus_req.rd;
	always @(negedge sys_clk) if (pend && expq.size() > 0) check(bus_rdata, expq.pop_front());

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		close_out();
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		for (int p = 0; p < 8; p++) rd(dir_at(p), 8'h00);
		for (int p = 0; p < 8; p++) begin
			d = 8'($random(seed));
			wr(data_at(p), d);
			wr(dir_at(p), 8'hff);
			rd(dir_at(p), (p == 2) ? 8'hbf : PIO_DIR_MASK[p]);
			e = d & PIO_DATA_MASK[p] & ((p == 2) ? 8'hfb : 8'hff);
			lat[p] = e;
			rd(data_at(p), e);
			check(pin_oe[p], PIO_DIR_MASK[p]);
			if (p != 2) check(pin_out[p] & PIO_DATA_MASK[p], e);
		end
		@(posedge sys_clk);
		board_level <= {$random(seed), $random(seed)};
		d = 8'($random(seed));
		wr(data_at(0), d);
		wr(dir_at(0), 8'h0f);
		wr(data_at(0), ~d);
		repeat (4) @(posedge sys_clk);
		rd(data_at(0), (~d & 8'h0f) | (board_level[0] & 8'hf0));
		@(posedge sys_clk);
		analog_channel <= 5'h03;
		wr(data_at(1), d);
		for (int k = 0; k < 2; k++) begin
			e = k ? 8'hf0 : 8'hf8;
			wr(dir_at(1), e);
			repeat (4) @(posedge sys_clk);
			check(pin_oe[1], 8'hf0);
			rd(data_at(1), (d & e) | (board_level[1] & 8'h07));
		end
		// A write while the clock enable is low must not land
		clk_en <= 1'b0;
		wr(data_at(3), ~lat[3]);
		clk_en <= 1'b1;
		rd(data_at(3), lat[3]);
		// Reset right after a latch write keeps that value
		wr(data_at(0), 8'h5a);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		wr(dir_at(0), 8'hff);
		rd(data_at(0), 8'h5a);
		rd(dir_at(2), 8'h00);
		check(pin_oe[4], 8'h00);
		wr(dir_at(4), 8'hff);
		rd(data_at(4), lat[4]);
		repeat (3) @(posedge sys_clk);
		close_out();
	end
endmodule

`default_nettype wire
